// [rtl/dmf_loop_filter.sv]
`timescale 1ns/1ps
module dmf_loop_filter (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    input wire logic abort_input_pin,
    input wire logic receiver_enable_pin,
    input wire logic manual_detect_pin,
    input wire logic acq_detect,
    input wire logic symbol_strobe,
    input wire logic binary_mode,
    input wire logic signed [7:0] sym_i,
    input wire logic signed [7:0] sym_q,
    input wire logic signed [16:0] dot_in,
    input wire logic signed [16:0] cross_in,
    output logic signed [8:0] rot_i_out,
    output logic signed [8:0] rot_q_out,
    output logic signed [31:0] loop_filter_out,
    output logic burst_counter_clear,
    output logic burst_counters_active
);

    ////////////////////////////////////////////////////////////////////////

    dmf_pkg::dmf_core_state_type s;
    dmf_pkg::dmf_core_state_type next_s;
    dmf_front_if fif();

    logic abort_comb;
    logic mdet_rise;
    logic rx_fall;
    logic k1_on;
    logic k2_on;
    logic half_carry;
    logic freeze;
    logic loop_clear_dis;
    logic [4:0] k1_n;
    logic [4:0] k2_n;
    logic signed [31:0] lf_x;
    logic signed [31:0] prop_term;
    logic signed [31:0] integ_add;

    // decodes a byte address into a register index
    function automatic logic [7:0] reg_index(input logic [11:0] addr);
        if (addr[11:10] != 2'h0 || addr[1:0] != 2'h0) begin
            reg_index = dmf_pkg::IDX_NONE;
        end else begin
            reg_index = addr[9:2];
        end
    endfunction

    // gain codes above the legal top are held at the top
    function automatic logic [4:0] clamp_gain(input logic [6:0] ctrl);
        logic [4:0] g;
        g = ctrl[dmf_pkg::GAIN_LSB +: 5];
        clamp_gain = (g > dmf_pkg::GAIN_MAX) ? dmf_pkg::GAIN_MAX : g;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // front end: rotation, discriminator, viewport

    assign fif.rot_sel = s.rot_ctrl[dmf_pkg::ROT_ENA_BIT:dmf_pkg::ROT_DIR_BIT];
    assign fif.view_n = s.rot_ctrl[dmf_pkg::VIEW_LSB +: 4];
    assign fif.binary_mode = binary_mode;
    assign fif.i_in = sym_i;
    assign fif.q_in = sym_q;
    assign fif.dot_in = dot_in;
    assign fif.cross_in = cross_in;

    dmf_front u_front (
        .clk(clk),
        .reset_n(reset_n),
        .fif(fif.front)
    );

    ////////////////////////////////////////////////////////////////////////
    // combinational helpers

    assign abort_comb = s.abort_bit | abort_input_pin; // RULE2
    assign mdet_rise = manual_detect_pin & ~s.mdet_prev;
    assign rx_fall = ~receiver_enable_pin & s.rxen_prev;

    assign k1_on = s.k1_ctrl[dmf_pkg::ON_BIT];
    assign k2_on = s.k2_ctrl[dmf_pkg::ON_BIT];
    assign half_carry = s.k2_ctrl[dmf_pkg::HALF_BIT];
    assign freeze = s.k1_ctrl[dmf_pkg::FREEZE_BIT];
    assign loop_clear_dis = s.rot_ctrl[dmf_pkg::LCD_BIT];
    assign k1_n = clamp_gain(s.k1_ctrl);
    assign k2_n = clamp_gain(s.k2_ctrl);

    assign lf_x = {{24{fif.lf_in[7]}}, fif.lf_in}; // RULE18
    assign prop_term = k1_on ? (lf_x <<< k1_n) : 32'sh0000_0000; // RULE14 RULE15
    // one fractional bit below the output LSB carries the half
    assign integ_add = ((lf_x <<< k2_n) <<< 1)
                       | {31'h0000_0000, half_carry}; // RULE11 RULE13

    ////////////////////////////////////////////////////////////////////////

    always_comb begin
        next_s = s;

        // write address and data may arrive in either order
        if (s_axi_awvalid && s.awready) begin
            next_s.aw_held = 1'b1;
            next_s.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s.wready) begin
            next_s.w_held = 1'b1;
            next_s.w_data = s_axi_wdata;
            next_s.w_lane0 = s_axi_wstrb[0];
        end
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end
        if (s.aw_held && s.w_held && !s.bvalid) begin
            next_s.aw_held = 1'b0;
            next_s.w_held = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = dmf_pkg::RESP_OKAY;
            case (reg_index(s.aw_addr))
                dmf_pkg::IDX_ABORT: begin
                    if (s.w_lane0) begin
                        next_s.abort_bit = s.w_data[0];
                    end
                end
                dmf_pkg::IDX_ROT: begin
                    // bit 2 is stored as written; software keeps it zero
                    if (s.w_lane0) begin
                        next_s.rot_ctrl = s.w_data[7:0]; // RULE6
                    end
                end
                dmf_pkg::IDX_K2: begin
                    if (s.w_lane0) begin
                        next_s.k2_ctrl = s.w_data[6:0];
                    end
                end
                dmf_pkg::IDX_K1: begin
                    if (s.w_lane0) begin
                        next_s.k1_ctrl = s.w_data[6:0];
                    end
                end
                dmf_pkg::IDX_STATUS, dmf_pkg::IDX_LOOP_OUT: begin
                    next_s.bresp = dmf_pkg::RESP_OKAY;
                end
                default: begin
                    next_s.bresp = dmf_pkg::RESP_SLVERR;
                end
            endcase
        end
        next_s.awready = !next_s.aw_held && !next_s.bvalid;
        next_s.wready = !next_s.w_held && !next_s.bvalid;

        // read channel: answer one cycle after the address is taken
        if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s.arready) begin
            next_s.rvalid = 1'b1;
            next_s.rresp = dmf_pkg::RESP_OKAY;
            case (reg_index(s_axi_araddr))
                dmf_pkg::IDX_ABORT: begin
                    next_s.rdata = {31'h0000_0000, s.abort_bit};
                end
                dmf_pkg::IDX_ROT: begin
                    next_s.rdata = {24'h00_0000, s.rot_ctrl};
                end
                dmf_pkg::IDX_K2: begin
                    next_s.rdata = {25'h000_0000, s.k2_ctrl};
                end
                dmf_pkg::IDX_K1: begin
                    next_s.rdata = {25'h000_0000, s.k1_ctrl};
                end
                dmf_pkg::IDX_STATUS: begin
                    next_s.rdata = {16'h0000, s.abort_count,
                                    6'h00, s.abort_pend,
                                    s.counters_active};
                end
                dmf_pkg::IDX_LOOP_OUT: begin
                    next_s.rdata = s.lf_out;
                end
                default: begin
                    next_s.rdata = 32'h0000_0000;
                    next_s.rresp = dmf_pkg::RESP_SLVERR;
                end
            endcase
        end
        next_s.arready = !next_s.rvalid;

        // abort: sample, detect edge, execute one edge later
        next_s.abort_prev = abort_comb; // RULE19
        next_s.abort_pend = abort_comb & ~s.abort_prev; // RULE1 RULE2 RULE19
        next_s.abort_clear = s.abort_pend; // RULE3
        next_s.mdet_prev = manual_detect_pin;
        next_s.rxen_prev = receiver_enable_pin;
        if (acq_detect || mdet_rise) begin
            next_s.counters_active = 1'b1; // RULE4
        end
        // an abort executing in the same cycle as a detect wins
        if (s.abort_pend) begin
            next_s.counters_active = 1'b0; // RULE3 RULE4
            next_s.abort_count = s.abort_count + 8'h01;
        end

        // loop filter, one step per symbol
        if (symbol_strobe && !freeze && k2_on) begin
            next_s.integ = s.integ + integ_add; // RULE11 RULE13 RULE18
        end
        if (rx_fall && !loop_clear_dis) begin
            next_s.integ = 32'sh0000_0000; // RULE7
        end
        if (!k2_on) begin
            next_s.integ = 32'sh0000_0000; // RULE12
        end
        if (symbol_strobe && !freeze) begin // RULE16
            next_s.lf_out = prop_term + (next_s.integ >>> 1); // RULE18
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s <= '0;
            s.rot_ctrl <= dmf_pkg::ROT_RESET;
            s.k2_ctrl <= dmf_pkg::K2_RESET;
            s.k1_ctrl <= dmf_pkg::K1_RESET;
            s.awready <= 1'b1;
            s.wready <= 1'b1;
            s.arready <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////

    assign s_axi_awready = s.awready;
    assign s_axi_wready = s.wready;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = s.arready;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;
    assign rot_i_out = fif.rot_i;
    assign rot_q_out = fif.rot_q;
    assign loop_filter_out = s.lf_out;
    assign burst_counter_clear = s.abort_clear;
    assign burst_counters_active = s.counters_active;

    ////////////////////////////////////////////////////////////////////////

    AST_ABORT_TWO_EDGES: assert property (@(posedge clk) // RULE3
        disable iff (!reset_n)
        $rose(abort_comb) |-> !s.abort_clear ##1 !s.abort_clear ##1 s.abort_clear)
        else $error("abort not executed on second edge");

    AST_ABORT_BIT_PIN_LOW: assert property (@(posedge clk) // RULE1
        disable iff (!reset_n)
        $rose(s.abort_bit) && !abort_input_pin && !$past(abort_input_pin)
        |-> ##2 s.abort_clear)
        else $error("abort bit edge ignored while pin low");

    AST_ABORT_PIN_BIT_LOW: assert property (@(posedge clk) // RULE2
        disable iff (!reset_n)
        $rose(abort_input_pin) && !s.abort_bit && !$past(s.abort_bit)
        |-> ##2 s.abort_clear)
        else $error("abort pin edge ignored while bit low");

    AST_ABORT_ONE_SHOT: assert property (@(posedge clk) // RULE19
        disable iff (!reset_n)
        s.abort_clear |=> !s.abort_clear)
        else $error("held abort produced more than one abort");

    AST_ABORT_CLEARS: assert property (@(posedge clk) // RULE3
        disable iff (!reset_n)
        s.abort_clear |-> !s.counters_active)
        else $error("counters still active after abort");

    AST_STAY_IDLE: assert property (@(posedge clk) // RULE4
        disable iff (!reset_n)
        !s.counters_active && !acq_detect && !mdet_rise
        |=> !s.counters_active)
        else $error("counters reactivated without a detect");

    AST_DETECT_WAKES: assert property (@(posedge clk) // RULE4
        disable iff (!reset_n)
        acq_detect && !s.abort_pend
        |=> s.counters_active)
        else $error("preamble detect did not reactivate counters");

    AST_MDET_WAKES: assert property (@(posedge clk) // RULE4
        disable iff (!reset_n)
        mdet_rise && !s.abort_pend
        |=> s.counters_active)
        else $error("manual detect did not reactivate counters");

    AST_K2_OFF_CLEAR: assert property (@(posedge clk) // RULE12
        disable iff (!reset_n)
        !k2_on |=> s.integ == 32'sh0000_0000)
        else $error("integral accumulator not held clear");

    AST_RX_FALL_CLEAR: assert property (@(posedge clk) // RULE7
        disable iff (!reset_n)
        rx_fall && !loop_clear_dis |=> s.integ == 32'sh0000_0000)
        else $error("receiver disable did not clear accumulator");

    AST_RX_FALL_KEEP: assert property (@(posedge clk) // RULE7
        disable iff (!reset_n)
        rx_fall && loop_clear_dis && k2_on && !symbol_strobe
        |=> $stable(s.integ))
        else $error("accumulator changed with clear disabled");

    AST_HALF_CARRY: assert property (@(posedge clk) // RULE13
        disable iff (!reset_n)
        symbol_strobe && k2_on && !freeze && !rx_fall
        |=> s.integ[0] == ($past(s.integ[0]) ^ $past(half_carry)))
        else $error("half LSB carry not applied");

    AST_FREEZE_HOLD: assert property (@(posedge clk) // RULE16
        disable iff (!reset_n)
        freeze |=> $stable(s.lf_out))
        else $error("loop output moved while frozen");

    AST_PROP_OFF: assert property (@(posedge clk) // RULE15
        disable iff (!reset_n)
        symbol_strobe && !freeze && !k1_on
        |=> s.lf_out == ($past(next_s.integ) >>> 1))
        else $error("proportional path contributed while disabled");

endmodule // dmf_loop_filter

// [rtl/dmf_pkg.sv]
// What this block does
// RULE1: abort bit rising, pin low, starts abort
// RULE2: abort bit ORed with abort pin
// RULE3: abort executes on second clock edge
// RULE4: counters idle until detect or manual detect
// RULE5: rotation select: none, +45, -45 degrees
// RULE6: software writes zero to rotation bit 2
// RULE7: receiver enable fall clears integral accumulator
// RULE8: software picks loop clear disable per oscillators
// RULE9: viewport picks bits n+7 to n
// RULE10: viewport overflow saturates to window limits
// RULE11: integral input scaled by two to n
// RULE12: integral enable low holds accumulator cleared
// RULE13: half carry adds half LSB per symbol
// RULE14: proportional input scaled by two to n
// RULE15: proportional enable low disables that path
// RULE16: freeze holds loop filter output constant
// RULE17: discriminator binary or quadrature product form
// RULE18: signed arithmetic; output is sum, per symbol
// RULE19: sampled abort edges give one abort each
package dmf_pkg;

    localparam int AXI_AW = 12;

    // printed offsets are register indexes; byte address is index * 4
    localparam logic [7:0] IDX_ABORT = 8'h32;
    localparam logic [7:0] IDX_ROT = 8'h33;
    localparam logic [7:0] IDX_K2 = 8'h34;
    localparam logic [7:0] IDX_K1 = 8'h35;
    localparam logic [7:0] IDX_STATUS = 8'h3B;
    localparam logic [7:0] IDX_LOOP_OUT = 8'h3C;
    localparam logic [7:0] IDX_NONE = 8'hFF;

    localparam int ROT_DIR_BIT = 0;
    localparam int ROT_ENA_BIT = 1;
    localparam int LCD_BIT = 3;
    localparam int VIEW_LSB = 4;
    localparam int GAIN_LSB = 0;
    localparam int ON_BIT = 5;
    localparam int HALF_BIT = 6;
    localparam int FREEZE_BIT = 6;

    localparam logic [3:0] VIEW_MAX = 4'h9;
    localparam logic [4:0] GAIN_MAX = 5'h15;

    localparam logic [7:0] ROT_RESET = 8'h00;
    localparam logic [6:0] K2_RESET = 7'h00;
    localparam logic [6:0] K1_RESET = 7'h00;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic aw_held;
        logic w_held;
        logic [AXI_AW-1:0] aw_addr;
        logic [31:0] w_data;
        logic w_lane0;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic abort_bit;
        logic [7:0] rot_ctrl;
        logic [6:0] k2_ctrl;
        logic [6:0] k1_ctrl;
        logic abort_prev;
        logic abort_pend;
        logic abort_clear;
        logic counters_active;
        logic [7:0] abort_count;
        logic mdet_prev;
        logic rxen_prev;
        logic signed [31:0] integ;
        logic signed [31:0] lf_out;
    } dmf_core_state_type;

    typedef struct packed {
        logic signed [8:0] rot_i;
        logic signed [8:0] rot_q;
        logic signed [16:0] disc;
        logic signed [7:0] lf_in;
    } dmf_front_state_type;

endpackage

// [rtl/dmf_front_if.sv]
`timescale 1ns/1ps
interface dmf_front_if;
    logic [1:0] rot_sel;
    logic [3:0] view_n;
    logic binary_mode;
    logic signed [7:0] i_in;
    logic signed [7:0] q_in;
    logic signed [16:0] dot_in;
    logic signed [16:0] cross_in;
    logic signed [8:0] rot_i;
    logic signed [8:0] rot_q;
    logic signed [7:0] lf_in;

    modport front (
        input rot_sel,
        input view_n,
        input binary_mode,
        input i_in,
        input q_in,
        input dot_in,
        input cross_in,
        output rot_i,
        output rot_q,
        output lf_in
    );

    modport core (
        output rot_sel,
        output view_n,
        output binary_mode,
        output i_in,
        output q_in,
        output dot_in,
        output cross_in,
        input rot_i,
        input rot_q,
        input lf_in
    );
endinterface

// [rtl/dmf_front.sv]
`timescale 1ns/1ps
module dmf_front (
    input wire logic clk,
    input wire logic reset_n,
    dmf_front_if.front fif
);

    dmf_pkg::dmf_front_state_type s;
    dmf_pkg::dmf_front_state_type next_s;
    logic signed [16:0] view_val;
    logic [3:0] view_eff;

    function automatic logic signed [16:0] sat17(input logic signed [18:0] v);
        if (v > 19'sh0_FFFF) begin
            sat17 = 17'sh0_FFFF;
        end else if (v < -19'sh1_0000) begin
            sat17 = -17'sh1_0000;
        end else begin
            sat17 = v[16:0];
        end
    endfunction

    // out-of-range view codes behave as the widest window
    assign view_eff = (fif.view_n > dmf_pkg::VIEW_MAX) ? dmf_pkg::VIEW_MAX
                                                        : fif.view_n;
    assign view_val = s.disc >>> view_eff; // RULE9

    always_comb begin
        logic signed [8:0] ie;
        logic signed [8:0] qe;
        logic signed [18:0] cx;
        logic signed [18:0] dx;
        logic signed [18:0] t1;
        logic signed [18:0] t2;
        ie = {fif.i_in[7], fif.i_in};
        qe = {fif.q_in[7], fif.q_in};
        cx = {{2{fif.cross_in[16]}}, fif.cross_in};
        dx = {{2{fif.dot_in[16]}}, fif.dot_in};
        t1 = fif.dot_in[16] ? -cx : cx;
        t2 = fif.cross_in[16] ? -dx : dx;
        next_s = s;
        case (fif.rot_sel)
            2'h2: begin // RULE5
                next_s.rot_i = ie - qe;
                next_s.rot_q = qe + ie;
            end
            2'h3: begin // RULE5
                next_s.rot_i = ie + qe;
                next_s.rot_q = qe - ie;
            end
            default: begin
                next_s.rot_i = ie;
                next_s.rot_q = qe;
            end
        endcase
        next_s.disc = sat17(fif.binary_mode ? t1 : t1 - t2); // RULE17
        if (view_val > 17'sh0_007F) begin // RULE10
            next_s.lf_in = 8'sh7F;
        end else if (view_val < -17'sh0_0080) begin // RULE10
            next_s.lf_in = -8'sh80;
        end else begin
            next_s.lf_in = view_val[7:0]; // RULE9
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign fif.rot_i = s.rot_i;
    assign fif.rot_q = s.rot_q;
    assign fif.lf_in = s.lf_in;

    AST_ROT_MINUS: assert property (@(posedge clk) disable iff (!reset_n) // RULE5
        fif.rot_sel == 2'h3 |=> s.rot_i == $past(fif.i_in) + $past(fif.q_in))
        else $error("minus rotation I output wrong");

    AST_VIEW_SAT_HI: assert property (@(posedge clk) disable iff (!reset_n) // RULE10
        view_val > 17'sh0_007F |=> s.lf_in == 8'sh7F)
        else $error("viewport did not saturate high");

    AST_DISC_BIN: assert property (@(posedge clk) disable iff (!reset_n) // RULE17
        fif.binary_mode && !fif.dot_in[16] |=> s.disc == $past(fif.cross_in))
        else $error("binary discriminator wrong");

endmodule // dmf_front

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
logic clk = 1'h0;
logic reset_n = 1'h0;
logic awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0;
logic ab = 1'h0, rxe = 1'h1, md = 1'h0, acq = 1'h0, stb = 1'h0, bm = 1'h0;
logic awrdy, wrdy, bvld, arrdy, rvld, bcc, bca;
logic [11:0] awa = 12'h000, ara = 12'h000;
logic [31:0] wd = 32'h0000_0000, rdata, rdv;
logic [1:0] bresp, rresp, bs, rs;
logic signed [7:0] si = 8'h00, sq = 8'h00;
logic signed [16:0] dot = 17'h0_0000, crs = 17'h0_0000;
logic signed [8:0] ri, rq;
logic signed [31:0] lfo;
int n_errors = 0, num_checks = 0, cyc = 0, n_clr = 0, n0, ei, eq;
int integ = 0, e = 0, vw, lcd, k1g, k2g, k1on, k2on, half, frz, c, d;

dmf_loop_filter i_dut (.clk(clk), .reset_n(reset_n),
    .s_axi_awvalid(awv), .s_axi_awready(awrdy), .s_axi_awaddr(awa),
    .s_axi_awprot(3'h0), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_bvalid(bvld),
    .s_axi_bready(br), .s_axi_bresp(bresp), .s_axi_arvalid(arv),
    .s_axi_arready(arrdy), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rvld), .s_axi_rready(rr), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .abort_input_pin(ab), .receiver_enable_pin(rxe),
    .manual_detect_pin(md), .acq_detect(acq), .symbol_strobe(stb),
    .binary_mode(bm), .sym_i(si), .sym_q(sq), .dot_in(dot),
    .cross_in(crs), .rot_i_out(ri), .rot_q_out(rq),
    .loop_filter_out(lfo), .burst_counter_clear(bcc),
    .burst_counters_active(bca));

initial begin
    forever #12.5 clk = ~clk;
end

always @(posedge clk) begin
    cyc <= cyc + 1;
    if (bcc === 1'h1) n_clr <= n_clr + 1;
    // plenty of margin over the roughly 900 cycles the tests need
    if (cyc == 20000) begin
        n_errors = n_errors + 1;
        print_verdict();
    end
end

////////////////////////////////////////////////////////////////////////////
task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
        $display("ALL TESTS PASSED");
    else
        $display("TESTS FAILED");
    $finish;
endtask

task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    num_checks++;
    if (s !== x) begin
        n_errors++;
        $display("[FAIL] %s expected %h seen %h", nm, x, s);
    end
endtask

function automatic logic [11:0] ba(input logic [7:0] idx);
    return {2'h0, idx, 2'h0};
endfunction

task automatic wr(input logic [7:0] idx, input logic [31:0] v);
    @(posedge clk);
    awa <= ba(idx);
    wd <= v;
    awv <= 1'h1;
    wv <= 1'h1;
    br <= 1'h1;
    do begin
        @(posedge clk);
        if (awrdy) awv <= 1'h0;
        if (wrdy) wv <= 1'h0;
    end while (bvld !== 1'h1);
    br <= 1'h0;
    bs = bresp;
endtask

task automatic rd(input logic [7:0] idx);
    @(posedge clk);
    ara <= ba(idx);
    arv <= 1'h1;
    rr <= 1'h1;
    do begin
        @(posedge clk);
        if (arrdy) arv <= 1'h0;
    end while (rvld !== 1'h1);
    rr <= 1'h0;
    rdv = rdata;
    rs = rresp;
endtask

////////////////////////////////////////////////////////////////////////////
// integer model of discriminator, viewport and saturation
function automatic int lfin(input int cr, input int dt, input int b, input int n);
    int v;
    v = (dt < 0) ? -cr : cr;
    if (b == 0) v = v - ((cr < 0) ? -dt : dt);
    if (v > 65535) v = 65535;
    if (v < -65536) v = -65536;
    v = v >>> n;
    if (v > 127) v = 127;
    if (v < -128) v = -128;
    return v;
endfunction

task automatic cfg(input int v, input int k2, input int k1);
    wr(dmf_pkg::IDX_ROT, v);
    wr(dmf_pkg::IDX_K2, k2);
    wr(dmf_pkg::IDX_K1, k1);
    vw = (v >> 4) & 15;
    lcd = (v >> 3) & 1;
    k2g = k2 & 31;
    k2on = (k2 >> 5) & 1;
    half = (k2 >> 6) & 1;
    k1g = k1 & 31;
    k1on = (k1 >> 5) & 1;
    frz = (k1 >> 6) & 1;
    if (k2on == 0) integ = 0;
endtask

task automatic step();
    int x;
    c = $signed(17'($urandom)) >>> ($urandom % 17);
    d = $signed(17'($urandom)) >>> ($urandom % 17);
    @(posedge clk);
    crs <= 17'(c);
    dot <= 17'(d);
    bm <= 1'($urandom % 2);
    // front pipeline is two cycles deep; let it settle first
    repeat (3) @(posedge clk);
    stb <= 1'h1;
    @(posedge clk);
    stb <= 1'h0;
    repeat (3) @(posedge clk);
    x = lfin(c, d, bm, vw);
    if (frz == 0) begin
        if (k2on != 0) integ = integ + (x <<< k2g) * 2 + half;
        e = ((k1on != 0) ? (x <<< k1g) : 0) + (integ >>> 1);
    end
    chk("loop_out", lfo, e);
endtask

task automatic rx_fall();
    @(posedge clk);
    rxe <= 1'h0;
    repeat (2) @(posedge clk);
    rxe <= 1'h1;
    if (lcd == 0) integ = 0;
endtask

////////////////////////////////////////////////////////////////////////////
initial begin
    void'($urandom(20));
    repeat (4) @(posedge clk);
    reset_n <= 1'h1;
    for (int i = 0; i < 3; i++) begin
        rd(dmf_pkg::IDX_ROT + 8'(i));
        chk("reg_reset", rdv, 0);
        ei = (i == 0) ? ($urandom & 32'h0000_00FB) : ($urandom & 32'h0000_007F);
        wr(dmf_pkg::IDX_ROT + 8'(i), ei);
        rd(dmf_pkg::IDX_ROT + 8'(i));
        chk("reg_back", rdv, ei);
        chk("reg_resp", rs, dmf_pkg::RESP_OKAY);
    end
    wr(dmf_pkg::IDX_NONE, 32'h0000_00FF);
    chk("bad_wr", bs, dmf_pkg::RESP_SLVERR);
    rd(dmf_pkg::IDX_NONE);
    chk("bad_rd", {rdv[29:0], rs}, dmf_pkg::RESP_SLVERR);
    for (int s = 0; s < 4; s++) begin
        wr(dmf_pkg::IDX_ROT, s);
        repeat (4) begin
            @(posedge clk);
            si <= 8'($urandom);
            sq <= 8'($urandom);
            repeat (2) @(posedge clk);
            ei = (s < 2) ? si : ((s == 2) ? si - sq : si + sq);
            eq = (s < 2) ? sq : ((s == 2) ? sq + si : sq - si);
            chk("rot_i", ri, ei);
            chk("rot_q", rq, eq);
        end
    end
    for (int n = 0; n < 10; n++) begin
        cfg(n << 4, 0, 32'h20);
        repeat (3) step();
    end
    for (int t = 0; t < 6; t++) begin
        cfg(($urandom % 10) << 4, ($urandom & 32'h60) | ($urandom % 22),
            ($urandom & 32'h20) | ($urandom % 22));
        repeat (3) step();
    end
    cfg(0, 32'h61, 32'h22);
    repeat (2) step();
    cfg(0, 32'h21, 32'h60);
    step();
    cfg(0, 32'h21, 32'h20);
    step();
    rx_fall();
    step();
    cfg(32'h08, 32'h21, 32'h20);
    rx_fall();
    step();
    cfg(0, 32'h01, 32'h20);
    step();
    @(posedge clk);
    acq <= 1'h1;
    @(posedge clk);
    acq <= 1'h0;
    repeat (2) @(posedge clk);
    chk("active", bca, 1);
    ab <= 1'h1;
    repeat (2) @(posedge clk);
    #1;
    chk("clear", bcc, 1);
    chk("active", bca, 0);
    n0 = n_clr;
    repeat (8) @(posedge clk);
    chk("aborts", n_clr - n0, 1);
    n0 = n_clr;
    wr(dmf_pkg::IDX_ABORT, 1);
    repeat (6) @(posedge clk);
    chk("aborts", n_clr - n0, 0);
    ab <= 1'h0;
    wr(dmf_pkg::IDX_ABORT, 0);
    n0 = n_clr;
    wr(dmf_pkg::IDX_ABORT, 1);
    repeat (6) @(posedge clk);
    chk("aborts", n_clr - n0, 1);
    chk("active", bca, 0);
    md <= 1'h1;
    repeat (3) @(posedge clk);
    chk("active", bca, 1);
    md <= 1'h0;
    print_verdict();
end
endmodule // tb_top
